/* aacd_defs.svh */
// constants for the address alias conflict detector
`ifndef AACD_DEFS_SVH
`define AACD_DEFS_SVH
`define AACD_ADDR_W 32
`define AACD_LINE_LSB 6
`define AACD_HI_BIT_V0 15
`define AACD_HI_BIT_V1 21
`define AACD_TRACE_LSB 14
`define AACD_FWD_LSB 12
`define AACD_PAGE_LSB 12
`define AACD_INFLIGHT 4
`define AACD_INFLIGHT_W 2
`define AACD_STORES 4
`define AACD_STORES_W 2
`define AACD_CODE_PAGES 8
`define AACD_CODE_PAGES_W 3
`define AACD_LINES_PER_PAGE 64
`define AACD_FLUSH_CYCLES 4
`endif

/* aacd_pkg.sv */
// types for the address alias conflict detector
package aacd_pkg;
	typedef enum logic [1:0] {
		AACD_RUN,
		AACD_FLUSH
	} aacd_state_t;
endpackage

/* aacd_page_mem.sv */
// small memory of code page tags with a registered read port
`timescale 1ns/1ps
`include "aacd_defs.svh"
module aacd_page_mem (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic WR_EN,
	input wire logic [`AACD_CODE_PAGES_W-1:0] WR_IDX,
	input wire logic [`AACD_ADDR_W-`AACD_PAGE_LSB:0] WR_DATA,
	input wire logic CLR_ALL,
	input wire logic [`AACD_CODE_PAGES_W-1:0] RD_IDX,
	output logic [`AACD_ADDR_W-`AACD_PAGE_LSB:0] RD_DATA
);
	// each word: valid bit on top, page number below
	logic [`AACD_ADDR_W-`AACD_PAGE_LSB:0] mem [`AACD_CODE_PAGES];
	logic [`AACD_ADDR_W-`AACD_PAGE_LSB:0] next_rd;

	always_comb begin
		next_rd = mem[RD_IDX];
	end

	// clear drops every valid bit so the flush empties the table
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < `AACD_CODE_PAGES; i++) begin
				mem[i] <= '0;
			end
			RD_DATA <= '0;
		end else begin
			RD_DATA <= next_rd;
			if (CLR_ALL) begin
				for (int i = 0; i < `AACD_CODE_PAGES; i++) begin
					mem[i] <= '0;
				end
			end else if (WR_EN) begin
				mem[WR_IDX] <= WR_DATA;
			end
		end
	end
endmodule // aacd_page_mem

/* aacd_detector.sv */
// address alias conflict detector: l1 conflicts, trace aliasing, forwarding stall, self-modify flush
`timescale 1ns/1ps
`include "aacd_defs.svh"
module aacd_detector #(
	parameter bit VARIANT = 1'b0
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic REF_VALID,
	input wire logic [`AACD_ADDR_W-1:0] REF_ADDR,
	input wire logic REF_IS_STORE,
	input wire logic [`AACD_INFLIGHT_W-1:0] REF_SLOT,
	input wire logic REF_DONE,
	input wire logic [`AACD_INFLIGHT_W-1:0] REF_DONE_SLOT,
	input wire logic EVICT_VALID,
	input wire logic [`AACD_ADDR_W-1:0] EVICT_ADDR,
	input wire logic STORE_DATA_READY,
	input wire logic [`AACD_STORES_W-1:0] STORE_DATA_SLOT,
	input wire logic TRACE_FILL,
	input wire logic [`AACD_ADDR_W-1:0] TRACE_ADDR,
	input wire logic CODE_FETCH,
	input wire logic [`AACD_ADDR_W-1:0] CODE_ADDR,
	output logic REF_START,
	output logic REF_HOLD,
	output logic LOAD_STALL,
	output logic [`AACD_ADDR_W-1:0] TRACE_EVICT_ADDR,
	output logic TRACE_EVICT,
	output logic SELF_MODIFY_FLUSH_CONDITION,
	output logic PIPE_FLUSH,
	output logic TRACE_FLUSH
);
	localparam int HI = VARIANT ? `AACD_HI_BIT_V1 : `AACD_HI_BIT_V0;
	localparam int PW = `AACD_ADDR_W - `AACD_PAGE_LSB;

	// l1 data conflict: same bits HI:6, low six ignored
	function automatic logic data_conflict(input logic [`AACD_ADDR_W-1:0] a, input logic [`AACD_ADDR_W-1:0] b);
		data_conflict = (a[HI:`AACD_LINE_LSB] == b[HI:`AACD_LINE_LSB]);
	endfunction

	// forwarding compare looks only below 4 KB
	function automatic logic fwd_alias(input logic [`AACD_ADDR_W-1:0] a, input logic [`AACD_ADDR_W-1:0] b);
		fwd_alias = (a[`AACD_FWD_LSB-1:`AACD_LINE_LSB] == b[`AACD_FWD_LSB-1:`AACD_LINE_LSB]);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// in-flight references, each with a resident-line flag
	logic [`AACD_INFLIGHT-1:0] inf_valid, next_inf_valid;
	logic [`AACD_INFLIGHT-1:0] inf_line, next_inf_line;
	logic [`AACD_INFLIGHT-1:0] inf_store, next_inf_store;
	logic [`AACD_ADDR_W-1:0] inf_addr [`AACD_INFLIGHT];
	logic [`AACD_ADDR_W-1:0] next_inf_addr [`AACD_INFLIGHT];
	logic [`AACD_INFLIGHT-1:0] hit_conflict, hit_fwd;
	logic next_start, next_hold, next_stall;
	logic flushing;

	// conflict vectors per slot
	genvar g;
	generate
		for (g = 0; g < `AACD_INFLIGHT; g++) begin : g_cmp
			// a line still resident (or its reference still going) blocks an alias
			assign hit_conflict[g] = (inf_valid[g] || inf_line[g]) && data_conflict(inf_addr[g], REF_ADDR);
			assign hit_fwd[g] = inf_valid[g] && inf_store[g] && !REF_IS_STORE && fwd_alias(inf_addr[g], REF_ADDR);
		end
	endgenerate

	// accept, hold or stall the offered reference
	always_comb begin
		next_inf_valid = inf_valid;
		next_inf_line = inf_line;
		next_inf_store = inf_store;
		next_inf_addr = inf_addr;
		next_start = 1'b0;
		next_hold = 1'b0;
		next_stall = 1'b0;
		for (int i = 0; i < `AACD_INFLIGHT; i++) begin
			// eviction of the line frees its alias group
			if (EVICT_VALID && inf_line[i] && data_conflict(inf_addr[i], EVICT_ADDR)) begin
				next_inf_line[i] = 1'b0;
			end
		end
		if (REF_DONE) begin
			next_inf_valid[REF_DONE_SLOT] = 1'b0;
		end
		if (STORE_DATA_READY) begin
			next_inf_store[STORE_DATA_SLOT] = 1'b0;
		end
		if (flushing) begin
			// pipeline clear drops all in-flight work
			next_inf_valid = '0;
			next_inf_store = '0;
		end else if (REF_VALID) begin
			if (|hit_fwd) begin
				next_stall = 1'b1;
			end else if (|hit_conflict) begin
				next_hold = 1'b1;
			end else begin
				next_start = 1'b1;
				next_inf_valid[REF_SLOT] = 1'b1;
				next_inf_line[REF_SLOT] = 1'b1;
				next_inf_store[REF_SLOT] = REF_IS_STORE;
				next_inf_addr[REF_SLOT] = REF_ADDR;
			end
		end
	end

	// in-flight table registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			inf_valid <= '0;
			inf_line <= '0;
			inf_store <= '0;
			for (int i = 0; i < `AACD_INFLIGHT; i++) begin
				inf_addr[i] <= '0;
			end
			REF_START <= 1'b0;
			REF_HOLD <= 1'b0;
			LOAD_STALL <= 1'b0;
		end else begin
			inf_valid <= next_inf_valid;
			inf_line <= next_inf_line;
			inf_store <= next_inf_store;
			inf_addr <= next_inf_addr;
			REF_START <= next_start;
			REF_HOLD <= next_hold;
			LOAD_STALL <= next_stall;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// trace cache 16K alias: one resident trace per low-14-bit start
	logic trc_valid, next_trc_valid;
	logic [`AACD_ADDR_W-1:0] trc_addr, next_trc_addr;
	logic next_trc_evict;
	logic [`AACD_ADDR_W-1:0] next_trc_evict_addr;

	// single tracker kept deliberately small; catches back-to-back aliasing fills
	always_comb begin
		next_trc_valid = trc_valid;
		next_trc_addr = trc_addr;
		next_trc_evict = 1'b0;
		next_trc_evict_addr = TRACE_EVICT_ADDR;
		if (flushing) begin
			next_trc_valid = 1'b0;
		end else if (TRACE_FILL) begin
			if (trc_valid && trc_addr != TRACE_ADDR
				&& trc_addr[`AACD_TRACE_LSB-1:0] == TRACE_ADDR[`AACD_TRACE_LSB-1:0]) begin
				next_trc_evict = 1'b1;
				next_trc_evict_addr = trc_addr;
			end
			next_trc_valid = 1'b1;
			next_trc_addr = TRACE_ADDR;
		end
	end

	// trace tracker registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			trc_valid <= 1'b0;
			trc_addr <= '0;
			TRACE_EVICT <= 1'b0;
			TRACE_EVICT_ADDR <= '0;
		end else begin
			trc_valid <= next_trc_valid;
			trc_addr <= next_trc_addr;
			TRACE_EVICT <= next_trc_evict;
			TRACE_EVICT_ADDR <= next_trc_evict_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// self-modify detection: code page table, scanned one entry per cycle
	aacd_pkg::aacd_state_t state, next_state;
	logic [`AACD_CODE_PAGES_W-1:0] scan_idx, next_scan_idx;
	logic [`AACD_CODE_PAGES_W-1:0] fill_idx, next_fill_idx;
	logic [PW:0] rd_word;
	logic [PW-1:0] wr_page, next_wr_page;
	logic wr_pend, next_wr_pend;
	logic [2:0] flush_cnt, next_flush_cnt;
	logic next_smc, next_pflush, next_tflush;
	logic pm_wr;
	logic [PW:0] pm_wdata;

	assign flushing = (state == aacd_pkg::AACD_FLUSH);
	// code fetch (direct or speculative) marks its page as code
	assign pm_wr = CODE_FETCH && !flushing;
	assign pm_wdata = {1'b1, CODE_ADDR[`AACD_ADDR_W-1:`AACD_PAGE_LSB]};

	aacd_page_mem u_pages (
		.MCLK(MCLK),
		.RST(RST),
		.WR_EN(pm_wr),
		.WR_IDX(fill_idx),
		.WR_DATA(pm_wdata),
		.CLR_ALL(flushing),
		.RD_IDX(scan_idx),
		.RD_DATA(rd_word)
	);

	// pages never fetched as code are absent, so prefilled data pages never flush
	always_comb begin
		next_state = state;
		next_scan_idx = scan_idx + 1'b1;
		next_fill_idx = pm_wr ? fill_idx + 1'b1 : fill_idx;
		next_wr_page = wr_page;
		next_wr_pend = wr_pend;
		next_flush_cnt = flush_cnt;
		next_smc = 1'b0;
		next_pflush = 1'b0;
		next_tflush = 1'b0;
		case (state)
			aacd_pkg::AACD_RUN: begin
				if (wr_pend && rd_word[PW] && rd_word[PW-1:0] == wr_page) begin
					next_smc = 1'b1;
					next_state = aacd_pkg::AACD_FLUSH;
					next_flush_cnt = 3'(`AACD_FLUSH_CYCLES - 1);
					next_wr_pend = 1'b0;
				end
				// newest store started is checked against every code page; set wins over the match clear
				if (next_start && REF_IS_STORE) begin
					next_wr_page = REF_ADDR[`AACD_ADDR_W-1:`AACD_PAGE_LSB];
					next_wr_pend = 1'b1;
				end
			end
			aacd_pkg::AACD_FLUSH: begin
				// hold flush so pipeline restarts from clean state
				next_pflush = 1'b1;
				next_tflush = 1'b1;
				next_fill_idx = '0;
				if (flush_cnt == 3'h0) begin
					next_state = aacd_pkg::AACD_RUN;
				end else begin
					next_flush_cnt = flush_cnt - 1'b1;
				end
			end
			default: begin
				next_state = aacd_pkg::AACD_RUN;
			end
		endcase
	end

	// self-modify registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state <= aacd_pkg::AACD_RUN;
			scan_idx <= '0;
			fill_idx <= '0;
			wr_page <= '0;
			wr_pend <= 1'b0;
			flush_cnt <= '0;
			SELF_MODIFY_FLUSH_CONDITION <= 1'b0;
			PIPE_FLUSH <= 1'b0;
			TRACE_FLUSH <= 1'b0;
		end else begin
			state <= next_state;
			scan_idx <= next_scan_idx;
			fill_idx <= next_fill_idx;
			wr_page <= next_wr_page;
			wr_pend <= next_wr_pend;
			flush_cnt <= next_flush_cnt;
			SELF_MODIFY_FLUSH_CONDITION <= next_smc;
			PIPE_FLUSH <= next_pflush;
			TRACE_FLUSH <= next_tflush;
		end
	end
endmodule // aacd_detector

/* aacd_props.sv */
// port assertions for the alias conflict detector
`timescale 1ns/1ps
module aacd_props (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic REF_VALID,
	input wire logic REF_IS_STORE,
	input wire logic TRACE_FILL,
	input wire logic [31:0] TRACE_ADDR,
	input wire logic REF_START,
	input wire logic REF_HOLD,
	input wire logic LOAD_STALL,
	input wire logic TRACE_EVICT,
	input wire logic [31:0] TRACE_EVICT_ADDR,
	input wire logic SELF_MODIFY_FLUSH_CONDITION,
	input wire logic PIPE_FLUSH,
	input wire logic TRACE_FLUSH
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// any answer to an offer
	wire logic ans = REF_START | REF_HOLD | LOAD_STALL;
	sequence flush_run;
		PIPE_FLUSH [*4] ##1 !PIPE_FLUSH;
	endsequence
	chk_one_answer:
		assert property ($onehot0({REF_START, REF_HOLD, LOAD_STALL})) else $error("two answers");
	chk_answer_cause:
		assert property (ans |-> $past(REF_VALID)) else $error("answer without offer");
	chk_stall_load:
		assert property (LOAD_STALL |-> !$past(REF_IS_STORE)) else $error("store stalled");
	chk_flush_len:
		assert property ($rose(PIPE_FLUSH) |-> flush_run) else $error("flush length");
	chk_flush_pair:
		assert property (PIPE_FLUSH == TRACE_FLUSH) else $error("flush halves differ");
	chk_smc_flush:
		assert property (SELF_MODIFY_FLUSH_CONDITION |-> ##[0:2] $rose(PIPE_FLUSH)) else $error("no flush");
	chk_flush_quiet:
		assert property (PIPE_FLUSH |-> !ans) else $error("answer in flush");
	chk_trace_evict:
		assert property (TRACE_EVICT |-> $past(TRACE_FILL) && TRACE_EVICT_ADDR != $past(TRACE_ADDR)
			&& ((TRACE_EVICT_ADDR ^ $past(TRACE_ADDR)) & 32'h0000_3fff) == 32'h0) else $error("bad evict");
endmodule // aacd_props
bind aacd_detector aacd_props u_props (.MCLK, .RST, .REF_VALID, .REF_IS_STORE, .TRACE_FILL, .TRACE_ADDR,
	.REF_START, .REF_HOLD, .LOAD_STALL, .TRACE_EVICT, .TRACE_EVICT_ADDR, .SELF_MODIFY_FLUSH_CONDITION,
	.PIPE_FLUSH, .TRACE_FLUSH);

/* aacd_pipe_model.sv */
// load/store and fetch pipeline model
`timescale 1ns/1ps
module aacd_pipe_model (
	input wire logic mclk,
	output logic ref_valid = 1'b0,
	output logic [31:0] ref_addr = 32'h0,
	output logic ref_is_store = 1'b0,
	output logic [1:0] ref_slot = 2'h0,
	output logic evict_valid = 1'b0,
	output logic store_data_ready = 1'b0,
	output logic trace_fill = 1'b0,
	output logic code_fetch = 1'b0,
	output logic ref_done = 1'b0,
	output logic [31:0] side_addr = 32'h0
);
	// one offer for one edge; caller judges the answer
	task automatic offer(input logic [31:0] a, input logic st, input logic [1:0] s);
		@(negedge mclk);
		ref_addr = a;
		ref_is_store = st;
		ref_slot = s;
		ref_valid = 1'b1;
		@(negedge mclk);
		ref_valid = 1'b0;
		ref_addr = ~a; // released bus shows no stale address
	endtask
	// side pulse: 0 evict, 1 data, 2 fill, 3 fetch, 4 done; slot is a[1:0]
	task automatic side(input int k, input logic [31:0] a);
		@(negedge mclk);
		side_addr = a;
		{ref_done, code_fetch, trace_fill, store_data_ready, evict_valid} = 5'h01 << k;
		@(negedge mclk);
		{ref_done, code_fetch, trace_fill, store_data_ready, evict_valid} = 5'h00;
		side_addr = ~a;
	endtask
endmodule // aacd_pipe_model

/* aacd_detector_bench.sv */
// self-checking bench for the alias conflict detector
`timescale 1ns/1ps
module aacd_detector_bench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ref_valid, ref_is_store, evict_valid, store_data_ready, trace_fill, code_fetch, ref_done;
	logic [1:0] ref_slot;
	logic [31:0] ref_addr, side_addr, te_addr;
	logic ref_start, ref_hold, load_stall, trace_evict, self_modify_flush_condition, pipe_flush, trace_flush;
	logic ref_start1, ref_hold1, load_stall1;
	int error_cnt = 0;
	int check_count = 0;
	aacd_pipe_model u_pipe (.mclk, .ref_valid, .ref_addr, .ref_is_store, .ref_slot, .evict_valid,
		.store_data_ready, .trace_fill, .code_fetch, .ref_done, .side_addr);
	aacd_detector #(.VARIANT(1'b0)) u_dut (.MCLK(mclk), .RST(rst), .REF_VALID(ref_valid), .REF_ADDR(ref_addr),
		.REF_IS_STORE(ref_is_store), .REF_SLOT(ref_slot), .REF_DONE(ref_done), .REF_DONE_SLOT(side_addr[1:0]),
		.EVICT_VALID(evict_valid), .EVICT_ADDR(side_addr), .STORE_DATA_READY(store_data_ready),
		.STORE_DATA_SLOT(side_addr[1:0]), .TRACE_FILL(trace_fill), .TRACE_ADDR(side_addr),
		.CODE_FETCH(code_fetch), .CODE_ADDR(side_addr), .REF_START(ref_start), .REF_HOLD(ref_hold),
		.LOAD_STALL(load_stall), .TRACE_EVICT_ADDR(te_addr), .TRACE_EVICT(trace_evict),
		.SELF_MODIFY_FLUSH_CONDITION(self_modify_flush_condition), .PIPE_FLUSH(pipe_flush), .TRACE_FLUSH(trace_flush));
	// second copy in the wide variant sees the same stimulus
	aacd_detector #(.VARIANT(1'b1)) u_dut_v1 (.MCLK(mclk), .RST(rst), .REF_VALID(ref_valid), .REF_ADDR(ref_addr),
		.REF_IS_STORE(ref_is_store), .REF_SLOT(ref_slot), .REF_DONE(ref_done), .REF_DONE_SLOT(side_addr[1:0]),
		.EVICT_VALID(evict_valid), .EVICT_ADDR(side_addr), .STORE_DATA_READY(store_data_ready),
		.STORE_DATA_SLOT(side_addr[1:0]), .TRACE_FILL(trace_fill), .TRACE_ADDR(side_addr),
		.CODE_FETCH(code_fetch), .CODE_ADDR(side_addr), .REF_START(ref_start1), .REF_HOLD(ref_hold1),
		.LOAD_STALL(load_stall1), .TRACE_EVICT_ADDR(), .TRACE_EVICT(), .SELF_MODIFY_FLUSH_CONDITION(),
		.PIPE_FLUSH(), .TRACE_FLUSH());
	initial begin
		forever #4 mclk = ~mclk;
	end
	////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// answer code: 1 start, 2 hold, 4 stall
	function automatic logic [31:0] ans();
		return {29'h0, load_stall, ref_hold, ref_start};
	endfunction
	// same code for the wide variant copy
	function automatic logic [31:0] ans1();
		return {29'h0, load_stall1, ref_hold1, ref_start1};
	endfunction
	task automatic do_reset();
		@(negedge mclk);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// store, then aliasing load stalls, holds, and starts once the line is gone
	task automatic t_conflict();
		u_pipe.offer(32'h0002_0040, 1'b1, 2'h0);
		check(ans(), 32'h1, "store");
		u_pipe.offer(32'h0003_0044, 1'b0, 2'h1);
		check(ans(), 32'h4, "stall");
		u_pipe.side(1, 32'h0);
		u_pipe.offer(32'h0003_0044, 1'b0, 2'h1);
		check(ans(), 32'h2, "hold");
		check(ans1(), 32'h1, "wide variant bit 16 apart");
		u_pipe.offer(32'h0002_1040, 1'b0, 2'h2);
		check(ans(), 32'h1, "bit 12 apart");
		u_pipe.side(4, 32'h0);
		u_pipe.side(0, 32'h0002_0040);
		u_pipe.offer(32'h0003_0044, 1'b0, 2'h1);
		check(ans(), 32'h1, "after evict");
		check(ans1(), 32'h2, "wide variant own alias");
		$display("t_conflict done");
	endtask
	// two trace starts 16K apart
	task automatic t_trace();
		u_pipe.side(2, 32'h0001_2345);
		check({31'h0, trace_evict}, 32'h0, "no evict");
		u_pipe.side(2, 32'h0001_6345);
		check({31'h0, trace_evict}, 32'h1, "evict");
		check(te_addr, 32'h0001_2345, "evict addr");
		$display("t_trace done");
	endtask
	// write to a fetched page flushes once; an unfetched page does not
	task automatic t_smc();
		logic [31:0] n;
		logic [31:0] f;
		logic [31:0] g;
		n = 0;
		f = 0;
		g = 0;
		u_pipe.side(3, 32'h0005_0000);
		u_pipe.offer(32'h0007_0100, 1'b1, 2'h0);
		repeat (16) begin
			@(negedge mclk);
			n += self_modify_flush_condition;
		end
		check(n, 0, "smc unfetched");
		u_pipe.offer(32'h0005_0200, 1'b1, 2'h1);
		repeat (24) begin
			@(negedge mclk);
			n += self_modify_flush_condition;
			f += pipe_flush;
			g += trace_flush;
		end
		check(n, 1, "smc count");
		check(f, 4, "flush cycles");
		check(g, 4, "trace flush cycles");
		u_pipe.offer(32'h0005_0800, 1'b0, 2'h2);
		check(ans(), 32'h1, "after flush");
		$display("t_smc done");
	endtask
	////////////////////////////////////////
	initial begin
		do_reset();
		t_conflict();
		do_reset();
		t_trace();
		do_reset();
		t_smc();
		end_of_test();
	end
	// cut a hang short
	initial begin
		repeat (2000) @(posedge mclk);
		error_cnt++;
		end_of_test();
	end
endmodule // aacd_detector_bench
